// >>> rtl/ppl_regs.vh
// Register indices, field positions and preset constants of the preset loader
`ifndef PPL_REGS_VH
`define PPL_REGS_VH

`define PPL_CFG_DEPTH      128
`define PPL_ANT_FIRST      7'h28
`define PPL_ANT_LAST       7'h39
`define PPL_COUNT_RESET    8'h12
`define PPL_PROTO_BASE     7'h48
`define PPL_PROTO_COUNT    5'h18
`define PPL_PROTO_LAST     5'h17

`define PPL_REG_CMD        8'h80
`define PPL_REG_PROTO_SEL  8'h81
`define PPL_REG_EE_ADDR_LO 8'h82
`define PPL_REG_EE_ADDR_HI 8'h83
`define PPL_REG_DEST       8'h84
`define PPL_REG_COUNT      8'h85
`define PPL_REG_STATUS     8'h86

`define PPL_CMD_PROTO_BIT  0
`define PPL_CMD_EEPROM_BIT 1
`define PPL_STAT_BUSY_BIT  0
`define PPL_STAT_DONE_BIT  1

`define PPL_EE_A106_FIRST  9'h0C0
`define PPL_EE_A106_LAST   9'h0D1

`endif

// >>> rtl/ppl_proto_rom.v
// Protocol coding preset table: one 24-byte set per protocol and bit rate
`default_nettype none
module ppl_proto_rom (
  input  wire [1:0] proto_sel,
  input  wire [4:0] slot,
  output reg  [7:0] value
);
  always @* begin
    case (slot)
      5'h00:   value = 8'h20; // R4
      5'h02:   value = {6'h01, proto_sel}; // R5 R6 R7 R8
      5'h03:   value = 8'h50; // R4
      5'h04:   value = {2'h1, proto_sel, 4'h0}; // R5 R6 R7 R8
      5'h0F:   value = 8'h50; // R4
      5'h10:   value = (proto_sel == 2'h0) ? 8'h02 : 8'h22; // R5 R6 R7 R8
      5'h13:   value = (proto_sel == 2'h0) ? 8'h01 : 8'h00; // R5 R6 R7 R8
      5'h15:   value = (proto_sel == 2'h0) ? 8'h08 : 8'h0D; // R5 R6 R7 R8
      5'h16:   value = 8'h80; // R4
      5'h17:   value = 8'hB2; // R4
      default: value = 8'h00; // R4
    endcase
  end
endmodule // ppl_proto_rom
`default_nettype wire

// >>> rtl/ppl_eeprom.v
// User EEPROM model holding the Type A 106 antenna preset set at C0..D1, one registered read port
`default_nettype none
module ppl_eeprom (
  input  wire       ref_clk,
  input  wire [8:0] rd_addr,
  output reg  [7:0] rd_data
);
  reg [7:0] lookup;

  always @* begin
    case (rd_addr)
      9'h0C0:  lookup = 8'h8E; // R11 R13
      9'h0C1:  lookup = 8'h12;
      9'h0C2:  lookup = 8'h39;
      9'h0C3:  lookup = 8'h0A;
      9'h0C4:  lookup = 8'h18;
      9'h0C5:  lookup = 8'h18;
      9'h0C6:  lookup = 8'h0F;
      9'h0C7:  lookup = 8'h21;
      9'h0C8:  lookup = 8'h00;
      9'h0C9:  lookup = 8'hC0;
      9'h0CA:  lookup = 8'h12;
      9'h0CB:  lookup = 8'hCF;
      9'h0CC:  lookup = 8'h00;
      9'h0CD:  lookup = 8'h04;
      9'h0CE:  lookup = 8'h90;
      9'h0CF:  lookup = 8'h5C;
      9'h0D0:  lookup = 8'h12;
      9'h0D1:  lookup = 8'h0A;
      default: lookup = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    rd_data <= lookup;
  end
endmodule // ppl_eeprom
`default_nettype wire

// >>> rtl/ppl_top.v
// Preset loader: configuration register file, Avalon-MM slave and load sequencer
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`include "ppl_regs.vh"
`default_nettype none

// Notes on behaviour
// [R1] Protocol command writes per-protocol coding presets
// [R2] Protocol command never touches antenna registers
// [R3] Host writes antenna setup on unpreset variant
// [R4] Common coding values in every protocol set
// [R5] First set: 04, 40, 02, 01, 08
// [R6] 212 kbit/s: 05, 50, 22, 00, 0D
// [R7] 424 kbit/s: 06, 60, receive as 212
// [R8] 848 kbit/s: 07, 70, receive as 212
// [R9] EEPROM command copies antenna presets to registers
// [R10] Antenna registers occupy 0x28 through 0x39
// [R11] EEPROM keeps one antenna preset per protocol; the model holds only the Type A 106 set
// [R12] Single register writes equal EEPROM load
// [R13] Type A 106 preset at C0..D1
// [R14] Host may tune loaded presets afterwards
// [R15] Ascending EEPROM bytes into consecutive registers
// [R16] Completion flagged only after last byte written
module ppl_top #(
  parameter CFG_DEPTH = `PPL_CFG_DEPTH
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg         load_busy,
  output reg         load_done
);
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_PROTO = 2'h1;
  localparam [1:0] ST_EE_RD = 2'h2;
  localparam [1:0] ST_EE_WR = 2'h3;

  reg  [7:0] cfg_mem [0:CFG_DEPTH-1];
  reg  [1:0] state_reg;
  reg  [1:0] proto_sel_reg;
  reg  [8:0] ee_addr_reg;
  reg  [6:0] dest_reg;
  reg  [7:0] count_reg;
  reg  [4:0] slot_reg;
  reg  [8:0] ee_ptr_reg;
  reg  [6:0] wr_ptr_reg;
  reg  [7:0] left_reg;
  reg  [7:0] rd_byte;
  wire [7:0] proto_value;
  wire [7:0] ee_value;
  wire       is_cfg;
  wire       granted;
  wire       bus_wr;
  wire       seq_wr;
  wire [6:0] seq_addr;
  wire [7:0] seq_data;
  integer    i;

  ppl_proto_rom u_proto_rom (
    .proto_sel (proto_sel_reg),
    .slot      (slot_reg),
    .value     (proto_value)
  );

  ppl_eeprom u_eeprom (
    .ref_clk (ref_clk),
    .rd_addr (ee_ptr_reg),
    .rd_data (ee_value)
  );

  assign is_cfg  = ~avs_address[7];
  // Configuration array accesses stall while a load owns the array
  assign granted = ~(is_cfg & load_busy);
  assign bus_wr  = avs_write & ~avs_waitrequest;

  // Sequencer write port; the protocol window sits outside 0x28..0x39
  assign seq_wr   = (state_reg == ST_PROTO) | (state_reg == ST_EE_WR); // R16
  assign seq_addr = (state_reg == ST_PROTO) ?
                    (`PPL_PROTO_BASE + {2'b00, slot_reg}) : wr_ptr_reg; // R2
  assign seq_data = (state_reg == ST_PROTO) ? proto_value : ee_value; // R1

  always @* begin
    rd_byte = 8'h00;
    if (is_cfg) begin
      rd_byte = cfg_mem[avs_address[6:0]];
    end else begin
      case (avs_address)
        `PPL_REG_PROTO_SEL:  rd_byte = {6'h00, proto_sel_reg};
        `PPL_REG_EE_ADDR_LO: rd_byte = ee_addr_reg[7:0];
        `PPL_REG_EE_ADDR_HI: rd_byte = {7'h00, ee_addr_reg[8]};
        `PPL_REG_DEST:       rd_byte = {1'b0, dest_reg};
        `PPL_REG_COUNT:      rd_byte = count_reg;
        `PPL_REG_STATUS:     rd_byte = {6'h00, load_done, load_busy};
        default:             rd_byte = 8'h00;
      endcase
    end
  end

  // Bus handshake: one wait cycle, more for a configuration access while a load is busy, then one cycle with waitrequest low
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read | avs_write) & avs_waitrequest & granted) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Configuration array: bus writes and sequencer writes never overlap
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      for (i = 0; i < CFG_DEPTH; i = i + 1) begin
        cfg_mem[i] <= 8'h00;
      end
    end else if (seq_wr) begin
      cfg_mem[seq_addr] <= seq_data; // R15
    end else if (bus_wr & is_cfg) begin
      cfg_mem[avs_address[6:0]] <= avs_writedata[7:0]; // R12
    end
  end

  // Parameter registers, command decode and sequencer
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      proto_sel_reg <= 2'h0;
      ee_addr_reg   <= `PPL_EE_A106_FIRST;
      dest_reg      <= `PPL_ANT_FIRST; // R10
      count_reg     <= `PPL_COUNT_RESET; // R13
      slot_reg      <= 5'h00;
      ee_ptr_reg    <= 9'h000;
      wr_ptr_reg    <= 7'h00;
      left_reg      <= 8'h00;
      load_busy     <= 1'b0;
      load_done     <= 1'b0;
    end else begin
      if (bus_wr & !load_busy) begin
        case (avs_address)
          `PPL_REG_PROTO_SEL:  proto_sel_reg   <= avs_writedata[1:0];
          `PPL_REG_EE_ADDR_LO: ee_addr_reg[7:0] <= avs_writedata[7:0];
          `PPL_REG_EE_ADDR_HI: ee_addr_reg[8]   <= avs_writedata[0];
          `PPL_REG_DEST:       dest_reg        <= avs_writedata[6:0];
          `PPL_REG_COUNT:      count_reg       <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (bus_wr && avs_address == `PPL_REG_STATUS &&
          avs_writedata[`PPL_STAT_DONE_BIT]) begin
        load_done <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (bus_wr && avs_address == `PPL_REG_CMD) begin
            if (avs_writedata[`PPL_CMD_PROTO_BIT]) begin
              state_reg <= ST_PROTO; // R1
              slot_reg  <= 5'h00;
              load_busy <= 1'b1;
            end else if (avs_writedata[`PPL_CMD_EEPROM_BIT]) begin
              ee_ptr_reg <= ee_addr_reg; // R9
              wr_ptr_reg <= dest_reg;
              left_reg   <= count_reg;
              if (count_reg == 8'h00) begin
                load_done <= 1'b1;
              end else begin
                state_reg <= ST_EE_RD;
                load_busy <= 1'b1;
              end
            end
          end
        end
        ST_PROTO: begin
          slot_reg <= slot_reg + 5'h01;
          if (slot_reg == `PPL_PROTO_LAST) begin
            state_reg <= ST_IDLE;
            load_busy <= 1'b0;
            load_done <= 1'b1; // R16
          end
        end
        ST_EE_RD: begin
          state_reg <= ST_EE_WR;
        end
        ST_EE_WR: begin
          ee_ptr_reg <= ee_ptr_reg + 9'h001; // R15
          wr_ptr_reg <= wr_ptr_reg + 7'h01; // R10
          left_reg   <= left_reg - 8'h01;
          if (left_reg == 8'h01) begin
            state_reg <= ST_IDLE;
            load_busy <= 1'b0;
            load_done <= 1'b1; // R16
          end else begin
            state_reg <= ST_EE_RD;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          load_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // ppl_top
`default_nettype wire

// >>> verif/ppl_chk_properties.sv
// Concurrent checks on the preset loader ports
`default_nettype none
module ppl_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        load_busy,
  input wire logic        load_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("access answered without a request");
  a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_busy_bound: assert property ($rose(load_busy) |-> ##[1:520] !load_busy)
    else $error("load never finished");
  a_busy_cause: assert property ($rose(load_busy) |-> $past(avs_write && !avs_waitrequest
    && avs_address == 8'h80 && avs_writedata[1:0] != 2'h0))
    else $error("load started without a command");
  a_done_cause: assert property ($rose(load_done) |-> $past(load_busy)
    || $past(avs_write && !avs_waitrequest && avs_address == 8'h80))
    else $error("done set without a load");
  a_done_at_end: assert property ($fell(load_busy) |-> load_done)
    else $error("done not set when load ended");
  a_done_clear: assert property ($fell(load_done) |-> $past(avs_write
    && !avs_waitrequest && avs_address == 8'h86 && avs_writedata[1]))
    else $error("done cleared without a status write");
endmodule // ppl_chk
bind ppl_top ppl_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .load_busy(load_busy), .load_done(load_done));
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the preset loader
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst_n, avs_read, avs_write;
  logic [7:0]  avs_address, q;
  logic [31:0] avs_writedata, seed;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, load_busy, load_done;
  int          m[128], mismatches, cmp_count, s, k;
  int          ee[18] = '{8'h8E, 8'h12, 8'h39, 8'h0A, 8'h18, 8'h18, 8'h0F, 8'h21, 8'h00,
                          8'hC0, 8'h12, 8'hCF, 8'h00, 8'h04, 8'h90, 8'h5C, 8'h12, 8'h0A};
  ppl_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .load_busy(load_busy), .load_done(load_done));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int pv(int p, int i);
    case (i)
      0: return 8'h20;
      2: return 8'h04 + p;
      3, 15: return 8'h50;
      4: return 8'h40 + 8'h10 * p;
      16: return p ? 8'h22 : 8'h02;
      19: return p ? 8'h00 : 8'h01;
      21: return p ? 8'h0D : 8'h08;
      22: return 8'h80;
      23: return 8'hB2;
      default: return 8'h00;
    endcase
  endfunction
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(string n, int e, logic [7:0] g);
    cmp_count++;
    if (g !== e[7:0]) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e[7:0], g);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 600);
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      results;
    end
    q = avs_readdata[7:0];
    if (w && !a[7]) m[a] = d;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rr(input logic [7:0] lo, input logic [7:0] hi);
    for (int i = lo; i <= hi; i++) begin
      acc(1'b0, i[7:0], 8'h00);
      chk($sformatf("reg %h", i[7:0]), m[i], q);
    end
  endtask
  task ld(input logic [7:0] c);
    int n;
    acc(1'b1, 8'h80, c);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (load_busy !== 1'b0 && n < 600);
    if (load_busy !== 1'b0) begin
      mismatches++;
      results;
    end
    chk("done", 1, {7'h00, load_done});
    acc(1'b1, 8'h86, 8'h02);
  endtask
  initial begin
    rst_n <= 1'b0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= 8'h00;
    avs_writedata <= 32'h00000000;
    seed = 32'h3A35AAEC;
    foreach (m[i]) m[i] = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    acc(1'b0, 8'h85, 8'h00);
    chk("count", 8'h12, q);
    for (k = 8'h28; k <= 8'h39; k++) begin
      seed = lfsr(seed);
      acc(1'b1, k[7:0], seed[7:0]);
    end
    rr(8'h28, 8'h39);
    $display("test host_writes done");
    for (s = 0; s < 4; s++) begin
      acc(1'b1, 8'h81, s[7:0]);
      ld(s == 2 ? 8'h03 : 8'h01);
      for (k = 0; k < 24; k++) m[8'h48 + k] = pv(s, k);
      rr(8'h48, 8'h5F);
      rr(8'h28, 8'h39);
    end
    acc(1'b1, 8'h5F, 8'h00);
    acc(1'b1, 8'h80, 8'h01);
    acc(1'b0, 8'h86, 8'h00);
    chk("status busy", 1, q);
    acc(1'b1, 8'h81, 8'h01);
    m[8'h5F] = pv(3, 23);
    rr(8'h5F, 8'h5F);
    acc(1'b0, 8'h81, 8'h00);
    chk("proto_sel", 3, q);
    acc(1'b0, 8'h86, 8'h00);
    chk("status done", 2, q);
    acc(1'b1, 8'h86, 8'h02);
    $display("test protocol done");
    ld(8'h02);
    for (k = 0; k < 18; k++) m[8'h28 + k] = ee[k];
    rr(8'h28, 8'h39);
    acc(1'b1, 8'h82, 8'hC4);
    acc(1'b1, 8'h84, 8'h30);
    acc(1'b1, 8'h85, 8'h03);
    ld(8'h02);
    for (k = 0; k < 3; k++) m[8'h30 + k] = ee[4 + k];
    rr(8'h28, 8'h39);
    seed = lfsr(seed);
    acc(1'b1, 8'h29, seed[7:0]);
    acc(1'b1, 8'h85, 8'h00);
    ld(8'h02);
    rr(8'h28, 8'h39);
    $display("test eeprom done");
    acc(1'b1, 8'h90, 8'h55);
    acc(1'b0, 8'h90, 8'h00);
    chk("unmapped", 0, q);
    $display("test unmapped done");
    acc(1'b1, 8'h80, 8'h01);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (m[i]) m[i] = 0;
    acc(1'b0, 8'h86, 8'h00);
    chk("status reset", 0, q);
    acc(1'b0, 8'h84, 8'h00);
    chk("dest", 8'h28, q);
    rr(8'h28, 8'h5F);
    $display("test reset done");
    results;
  end
endmodule // tb
`default_nettype wire
